/* File: src/pll_synth_control_registers.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RL1: register 2 bit picks divider double buffering
// RL2: lock function bit picks integer or fractional
// RL3: fractional lock after 40 in-window cycles
// RL4: integer lock after five in-window cycles
// RL5: polarity bit sets phase detector sense
// RL6: sleep bit powers down, registers kept
// RL7: sleep holds counters, pump, detector, rf off
// RL8: three-state bit floats the charge pump
// RL9: counter reset bit holds R and N
// RL10: select codes 3,4,5 load registers 3,4,5
// RL11: antibacklash bit picks 6 or 3 ns
// RL12: charge cancellation bit enables cancellation
// RL13: slip bit enables cycle slip reduction
// RL14: divider mode: resync, fast lock, off
// RL15: 12-bit value loads resync and fast timeout
// RL16: feedback bit picks oscillator or divider output
// RL17: three-bit field picks output divider ratio
// RL18: mute till lock keeps rf unpowered
// RL19: register 4 bit enables primary rf output
// RL20: two-bit field sets rf output power
// RL21: register 5 field picks lock pin function
// RL22: host writes registers 5 down to 0
// RL23: select codes 0,1,2 load registers 0,1,2
// RL24: pin low 00/10, lock 01, high 11
// RL25: fast lock lasts timer value detector cycles
// RL26: buffered divider applies on next register 0
module pll_synth_control_registers (
	mclk,
	rst_n,
	serClk,
	serData,
	serLatch,
	pfdTick,
	withinWide,
	withinTight,
	freqWord,
	modWord,
	countersHeld,
	pumpThreeState,
	polarityPositive,
	antibacklashShort,
	chargeCancel,
	slipReductionEnable,
	feedbackDirect,
	outDivSelect,
	rfOutputEnable,
	rfOutputPower,
	fastLockWide,
	resyncStrobe,
	lockDetect,
	lockPin
);
	localparam int W  = pll_ctrl_pkg::WORD_W;
	localparam int TW = pll_ctrl_pkg::TIMER_W;
	localparam int DW = pll_ctrl_pkg::DIV_W;

	input  wire logic          mclk;                // system clock
	input  wire logic          rst_n;               // sync reset, low
	input  wire logic          serClk;              // serial clock pin
	input  wire logic          serData;             // serial data pin
	input  wire logic          serLatch;            // load enable pin
	input  wire logic          pfdTick;             // detector cycle pulse
	input  wire logic          withinWide;          // error under 10 ns
	input  wire logic          withinTight;         // error under 6 ns
	output logic [W-1:0]       freqWord;            // register 0 word
	output logic [W-1:0]       modWord;             // register 1 word
	output logic               countersHeld;        // R and N in load state
	output logic               pumpThreeState;      // charge pump floated
	output logic               polarityPositive;    // detector polarity
	output logic               antibacklashShort;   // 3 ns pulse
	output logic               chargeCancel;        // cancellation on
	output logic               slipReductionEnable; // slip reduction on
	output logic               feedbackDirect;      // feedback from oscillator
	output logic [DW-1:0]      outDivSelect;        // active divider ratio
	output logic               rfOutputEnable;      // rf buffer powered
	output logic [1:0]         rfOutputPower;       // rf power level
	output logic               fastLockWide;        // wide bandwidth phase
	output logic               resyncStrobe;        // phase resync pulse
	output logic               lockDetect;          // digital lock
	output logic               lockPin;             // lock detect pin

	// ------------------------------------------------------------
	// serial pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] clkSync_r;        // serial clock, two stages
	logic [1:0] datSync_r;        // serial data, two stages
	logic [1:0] latSync_r;        // latch enable, two stages
	logic       clkPrev_r;        // last synced clock level
	logic       latPrev_r;        // last synced latch level
	logic       clkRise;          // serial clock rising
	logic       latRise;          // latch enable rising

	// two flops per pin, edge history taken from the second
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clkSync_r <= '0;
			datSync_r <= '0;
			latSync_r <= '0;
			clkPrev_r <= 1'b0;
			latPrev_r <= 1'b0;
		end else begin
			clkSync_r <= {clkSync_r[0], serClk};
			datSync_r <= {datSync_r[0], serData};
			latSync_r <= {latSync_r[0], serLatch};
			clkPrev_r <= clkSync_r[1];
			latPrev_r <= latSync_r[1];
		end
	end

	assign clkRise = clkSync_r[1] && !clkPrev_r;
	assign latRise = latSync_r[1] && !latPrev_r;

	// ------------------------------------------------------------
	// input shift register and word routing
	// ------------------------------------------------------------
	logic [W-1:0] shift_r;                            // msb first
	logic [W-1:0] regFile_r [pll_ctrl_pkg::NUM_REGS]; // registers 0 to 5
	logic [2:0]   selCode;                            // register_select_bits
	logic         wrR0;                               // register 0 written
	logic         wrR4;                               // register 4 written

	// shifting stays live in power-down
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_r <= pll_ctrl_pkg::REG_RESET;
		end else if (clkRise) begin
			shift_r <= {shift_r[W-2:0], datSync_r[1]};     // RL7
		end
	end

	assign selCode = shift_r[pll_ctrl_pkg::SEL_LSB +: pll_ctrl_pkg::SEL_W];
	assign wrR0    = latRise && selCode == pll_ctrl_pkg::SEL_R0;
	assign wrR4    = latRise && selCode == pll_ctrl_pkg::SEL_R4;

	// latch routes the word by its select code; 110 and 111 dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < pll_ctrl_pkg::NUM_REGS; i++) begin
				regFile_r[i] <= pll_ctrl_pkg::REG_RESET;
			end
		end else if (latRise && selCode <= pll_ctrl_pkg::SEL_R5) begin
			regFile_r[selCode] <= shift_r;                   // RL10 RL23 RL6
		end
	end

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	logic          sleep;       // software_sleep_bit
	logic          dblBuf;      // divider double buffering
	logic [1:0]    cdivMode;    // clock divider mode
	logic [TW-1:0] cdivValue;   // clock divider value
	logic          muteTillLock;
	logic [1:0]    pinMode;     // lock_pin_mode_high, lock_pin_mode_low

	assign sleep        = regFile_r[2][pll_ctrl_pkg::R2_SLEEP];     // RL6
	assign dblBuf       = regFile_r[2][pll_ctrl_pkg::R2_DBL_BUF];   // RL1
	assign cdivMode     = regFile_r[3][pll_ctrl_pkg::R3_MODE_LSB +: 2]; // RL14
	assign cdivValue    = regFile_r[3][pll_ctrl_pkg::R3_TIMER_LSB +: TW]; // RL15
	assign muteTillLock = regFile_r[4][pll_ctrl_pkg::R4_MUTE];
	assign pinMode      = regFile_r[5][pll_ctrl_pkg::R5_PIN_LSB +: 2]; // RL21

	assign freqWord            = regFile_r[0];
	assign modWord             = regFile_r[1];
	assign polarityPositive    = regFile_r[2][pll_ctrl_pkg::R2_POLARITY]; // RL5
	assign antibacklashShort   = regFile_r[3][pll_ctrl_pkg::R3_ABL_SHORT]; // RL11
	assign chargeCancel        = regFile_r[3][pll_ctrl_pkg::R3_CHG_CANC]; // RL12
	assign slipReductionEnable = regFile_r[3][pll_ctrl_pkg::R3_SLIP]; // RL13
	assign feedbackDirect      = regFile_r[4][pll_ctrl_pkg::R4_FB_DIRECT]; // RL16
	assign rfOutputPower       = regFile_r[4][pll_ctrl_pkg::R4_PWR_LSB +: 2]; // RL20

	// ------------------------------------------------------------
	// power-down and charge pump controls
	// ------------------------------------------------------------
	// pump floats on its own bit or in sleep
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pumpThreeState <= 1'b0;
		end else begin
			pumpThreeState <= regFile_r[2][pll_ctrl_pkg::R2_PUMP_3ST] || sleep; // RL8 RL7
		end
	end

	// counters held by reset bit or sleep
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			countersHeld <= 1'b0;
		end else begin
			countersHeld <= regFile_r[2][pll_ctrl_pkg::R2_CNT_RST] || sleep; // RL9 RL7
		end
	end

	// ------------------------------------------------------------
	// output divider with optional double buffer
	// ------------------------------------------------------------
	logic [DW-1:0] divPending_r;  // divider waiting for register 0

	// pending copy always follows the latest register 4 write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			divPending_r <= '0;
		end else if (wrR4) begin
			divPending_r <= shift_r[pll_ctrl_pkg::R4_DIV_LSB +: DW];
		end
	end

	// active ratio: direct on register 4, buffered on register 0
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			outDivSelect <= '0;
		end else if (wrR4 && !dblBuf) begin
			outDivSelect <= shift_r[pll_ctrl_pkg::R4_DIV_LSB +: DW]; // RL1 RL17
		end else if (wrR0 && dblBuf) begin
			outDivSelect <= divPending_r;                    // RL26
		end
	end

	// ------------------------------------------------------------
	// lock detector and rf output gating
	// ------------------------------------------------------------
	pll_lock_detect #(
		.FRAC_COUNT (pll_ctrl_pkg::LOCK_FRAC_COUNT),
		.INT_COUNT  (pll_ctrl_pkg::LOCK_INT_COUNT)
	) u_lock (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.clear       (sleep),                               // RL7
		.intMode     (regFile_r[2][pll_ctrl_pkg::R2_LOCK_FN]), // RL2
		.tightWindow (regFile_r[2][pll_ctrl_pkg::R2_LOCK_PREC]),
		.pfdTick     (pfdTick),
		.withinWide  (withinWide),
		.withinTight (withinTight),
		.locked      (lockDetect)
	);

	// rf buffer: enable bit, not asleep, not muted before lock
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rfOutputEnable <= 1'b0;
		end else begin
			rfOutputEnable <= regFile_r[4][pll_ctrl_pkg::R4_RF_EN] && !sleep // RL19 RL7
				&& !(muteTillLock && !lockDetect);          // RL18
		end
	end

	// lock pin multiplexer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lockPin <= 1'b0;
		end else begin
			unique case (pinMode)
				pll_ctrl_pkg::PIN_LOCK: lockPin <= lockDetect; // RL24
				pll_ctrl_pkg::PIN_HIGH: lockPin <= 1'b1;       // RL24
				default:                lockPin <= 1'b0;       // 00 and 10
			endcase
		end
	end

	// ------------------------------------------------------------
	// clock divider timeout: fast lock and phase resync
	// ------------------------------------------------------------
	logic [TW-1:0] timeout_r;     // detector cycles left
	logic          timing_r;      // timeout in progress

	// armed by a register 0 write, counted in detector cycles
	always_ff @(posedge mclk) begin
		if (!rst_n || sleep) begin
			timeout_r    <= '0;
			timing_r     <= 1'b0;
			fastLockWide <= 1'b0;
			resyncStrobe <= 1'b0;
		end else if (wrR0 && cdivMode != pll_ctrl_pkg::CDIV_OFF
				&& cdivValue != '0) begin
			timeout_r    <= cdivValue;                       // RL15
			timing_r     <= 1'b1;
			fastLockWide <= cdivMode == pll_ctrl_pkg::CDIV_FAST; // RL25
			resyncStrobe <= 1'b0;
		end else if (timing_r && pfdTick) begin
			timeout_r    <= timeout_r - TW'(1);
			resyncStrobe <= 1'b0;
			if (timeout_r == TW'(1)) begin
				timing_r     <= 1'b0;
				fastLockWide <= 1'b0;                        // RL25
				resyncStrobe <= cdivMode == pll_ctrl_pkg::CDIV_RESYNC; // RL14
			end
		end else begin
			resyncStrobe <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_route_high_regs: assert property (latRise && selCode == pll_ctrl_pkg::SEL_R3
		|=> regFile_r[3] == $past(shift_r)) // RL10
		else $error("register 3 not loaded");
	a_route_low_regs: assert property (latRise && selCode == pll_ctrl_pkg::SEL_R0
		|=> regFile_r[0] == $past(shift_r) && freqWord == $past(shift_r)) // RL23
		else $error("register 0 not loaded");
	a_div_direct: assert property (wrR4 && !dblBuf
		|=> outDivSelect == $past(shift_r[pll_ctrl_pkg::R4_DIV_LSB +: DW])) // RL1
		else $error("direct divider not applied");
	a_div_buffered: assert property (wrR4 && dblBuf |=> $stable(outDivSelect)) // RL26
		else $error("buffered divider applied early");
	a_sleep_pump: assert property (sleep |=> pumpThreeState && countersHeld) // RL7
		else $error("sleep did not hold pump and counters");
	a_pump_float: assert property (!sleep && regFile_r[2][pll_ctrl_pkg::R2_PUMP_3ST]
		|=> pumpThreeState) // RL8
		else $error("three-state bit ignored");
	a_mute_rf: assert property (muteTillLock && !lockDetect |=> !rfOutputEnable) // RL18
		else $error("rf powered before lock");
	a_pin_high: assert property (pinMode == pll_ctrl_pkg::PIN_HIGH |=> lockPin) // RL24
		else $error("lock pin not high");
	a_pin_lock: assert property (pinMode == pll_ctrl_pkg::PIN_LOCK
		|=> lockPin == $past(lockDetect)) // RL24
		else $error("lock pin not following lock");

	c_sleep_entry: cover property ($rose(sleep));
	c_fast_lock: cover property ($rose(fastLockWide) ##[1:100] $fell(fastLockWide));
	c_buffered_apply: cover property (wrR0 && dblBuf);
	c_resync: cover property (resyncStrobe);
endmodule

/* File: src/pll_ctrl_pkg.sv */
package pll_ctrl_pkg;
	// ------------------------------------------------------------
	// serial word layout
	// ------------------------------------------------------------
	localparam int WORD_W    = 32;       // bits per serial word
	localparam int SEL_LSB   = 0;        // register_select_bits position
	localparam int SEL_W     = 3;        // register_select_bits width
	localparam int NUM_REGS  = 6;        // registers 0 to 5
	localparam logic [WORD_W-1:0] REG_RESET = 32'h0000_0000;

	// register_select_bits codes
	localparam logic [2:0] SEL_R0 = 3'h0;
	localparam logic [2:0] SEL_R1 = 3'h1;
	localparam logic [2:0] SEL_R2 = 3'h2;
	localparam logic [2:0] SEL_R3 = 3'h3;
	localparam logic [2:0] SEL_R4 = 3'h4;
	localparam logic [2:0] SEL_R5 = 3'h5;

	// ------------------------------------------------------------
	// loop_and_detector_config (register 2) fields
	// ------------------------------------------------------------
	localparam int R2_DBL_BUF   = 13;    // output divider double buffer
	localparam int R2_LOCK_FN   = 8;     // lock_function_select
	localparam int R2_LOCK_PREC = 7;     // lock_window_precision
	localparam int R2_POLARITY  = 6;     // phase detector polarity
	localparam int R2_SLEEP     = 5;     // software_sleep_bit
	localparam int R2_PUMP_3ST  = 4;     // pump_output three-state
	localparam int R2_CNT_RST   = 3;     // R and N counter reset

	// ------------------------------------------------------------
	// slip_and_timer_config (register 3) fields
	// ------------------------------------------------------------
	localparam int R3_ABL_SHORT = 22;    // antibacklash 3 ns when set
	localparam int R3_CHG_CANC  = 21;    // charge cancellation
	localparam int R3_SLIP      = 18;    // slip_reduction_enable
	localparam int R3_MODE_LSB  = 15;    // clock divider mode [16:15]
	localparam int R3_TIMER_LSB = 3;     // clock divider value [14:3]
	localparam int TIMER_W      = 12;    // clock divider value width

	typedef enum logic [1:0] {
		CDIV_OFF    = 2'h0,              // clock divider disabled
		CDIV_FAST   = 2'h1,              // fast lock
		CDIV_RESYNC = 2'h2,              // phase resync
		CDIV_RSVD   = 2'h3               // unused code
	} clk_div_mode_t;

	// ------------------------------------------------------------
	// output_path_config (register 4) fields
	// ------------------------------------------------------------
	localparam int R4_FB_DIRECT = 23;    // feedback straight from oscillator
	localparam int R4_DIV_LSB   = 20;    // output divider select [22:20]
	localparam int DIV_W        = 3;
	localparam int R4_MUTE      = 10;    // mute till lock
	localparam int R4_RF_EN     = 5;     // primary rf_output enable
	localparam int R4_PWR_LSB   = 3;     // output power [4:3]
	localparam int PWR_W        = 2;

	// ------------------------------------------------------------
	// lock_pin_config (register 5) fields
	// ------------------------------------------------------------
	localparam int R5_PIN_LSB   = 22;    // lock pin mode [23:22]
	localparam logic [1:0] PIN_LOCK = 2'h1;  // lock_pin_mode_high=0, low=1
	localparam logic [1:0] PIN_HIGH = 2'h3;  // both mode bits set

	// ------------------------------------------------------------
	// lock detector
	// ------------------------------------------------------------
	localparam int LOCK_FRAC_COUNT = 40; // fractional-N run length
	localparam int LOCK_INT_COUNT  = 5;  // integer-N run length
	localparam int LOCK_CNT_W      = 6;
	localparam int WINDOW_WIDE_NS  = 10; // precision bit 0
	localparam int WINDOW_TIGHT_NS = 6;  // precision bit 1
endpackage

/* File: src/pll_lock_detect.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// digital lock detector: counts phase detector cycles in window
// ------------------------------------------------------------
module pll_lock_detect #(
	parameter int FRAC_COUNT = pll_ctrl_pkg::LOCK_FRAC_COUNT,
	parameter int INT_COUNT  = pll_ctrl_pkg::LOCK_INT_COUNT
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic clear,         // power-down resets the detector
	input  wire logic intMode,       // lock_function_select
	input  wire logic tightWindow,   // lock_window_precision
	input  wire logic pfdTick,       // one pulse per detector cycle
	input  wire logic withinWide,    // phase error under wide window
	input  wire logic withinTight,   // phase error under tight window
	output logic      locked
);
	localparam int CW = pll_ctrl_pkg::LOCK_CNT_W;

	logic [CW-1:0] runCnt_r;         // consecutive in-window cycles
	logic [CW-1:0] target;           // run length for this mode
	logic          inWindow;         // sample falls within precision

	// run length and window per mode
	always_comb begin
		target   = intMode ? CW'(INT_COUNT) : CW'(FRAC_COUNT); // RL2
		inWindow = tightWindow ? withinTight : withinWide;      // RL3 RL4
	end

	// counter of consecutive good cycles
	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			runCnt_r <= '0;                                 // RL7
		end else if (pfdTick) begin
			if (!inWindow) begin
				runCnt_r <= '0;                         // miss restarts
			end else if (runCnt_r < target) begin
				runCnt_r <= runCnt_r + CW'(1);          // RL3 RL4
			end
		end
	end

	// lock flag follows the run counter
	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			locked <= 1'b0;
		end else if (pfdTick) begin
			locked <= inWindow && (runCnt_r + CW'(1) >= target);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_frac_run_len: assert property ($rose(locked) && !intMode |->
		$past(runCnt_r) == CW'(FRAC_COUNT - 1)) // RL3
		else $error("fractional lock raised at wrong count");
	// a run begun in fractional mode may already be past five cycles
	a_int_run_len: assert property ($rose(locked) && intMode |->
		$past(runCnt_r) >= CW'(INT_COUNT - 1)) // RL4
		else $error("integer lock raised at wrong count");
	a_clear_drops: assert property (clear |=> !locked && runCnt_r == '0) // RL7
		else $error("lock not reset by power-down");
	a_miss_unlocks: assert property (pfdTick && !inWindow && !clear |=> !locked) // RL3
		else $error("lock held after out of window cycle");
	c_int_lock: cover property (intMode && $rose(locked));
endmodule

/* File: testbench/serial_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the 3-wire serial port
// ------------------------------------------------------------
module serial_host_model (
	input  wire logic mclk,
	output logic      serClk,
	output logic      serData,
	output logic      serLatch
);
	// clock stands low outside words
	initial begin
		serClk = 1'b0;
		serData = 1'b0;
		serLatch = 1'b0;
	end

	// msb first, 4 mclk cycles high clear the 3-cycle minimum
	task automatic send_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(negedge mclk);
			serData = w[i];
			@(negedge mclk);
			serClk = 1'b1;
			repeat (4) @(negedge mclk);
			serClk = 1'b0;
			repeat (3) @(negedge mclk);
		end
		// gap before latch; data released, so show its inverse
		repeat (4) @(negedge mclk);
		serLatch = 1'b1;
		serData = ~serData;
		repeat (4) @(negedge mclk);
		serLatch = 1'b0;
	endtask
endmodule

/* File: testbench/test_pll_synth_control_registers.sv */
`timescale 1ns/1ps
module test_pll_synth_control_registers;
	logic        mclk = 1'b0;        // 50 MHz
	logic        rst_n = 1'b0;       // held low at start
	logic        pfdTick = 1'b0;     // detector cycle pulse
	logic        withinWide = 1'b0;  // error under wide window
	logic        withinTight = 1'b0; // error under tight window
	logic        serClk;             // from host model
	logic        serData;
	logic        serLatch;
	logic [31:0] freqWord;
	logic [31:0] modWord;
	logic        countersHeld;
	logic        pumpThreeState;
	logic        polarityPositive;
	logic        antibacklashShort;
	logic        chargeCancel;
	logic        slipReductionEnable;
	logic        feedbackDirect;
	logic [2:0]  outDivSelect;
	logic        rfOutputEnable;
	logic [1:0]  rfOutputPower;
	logic        fastLockWide;
	logic        resyncStrobe;
	logic        lockDetect;
	logic        lockPin;
	int          failures = 0;       // mismatches
	int          checked = 0;        // comparisons
	int          cycles = 0;         // timeout count
	int          pulses = 0;         // resync strobes seen
	int          pulseBase = 0;      // strobe count at scenario start
	localparam logic [31:0] F0 = 32'h1234_5670; // register 0 word

	always #10 mclk = ~mclk;

	serial_host_model host_u (.mclk(mclk), .serClk(serClk), .serData(serData),
		.serLatch(serLatch));

	pll_synth_control_registers dut_u (.mclk(mclk), .rst_n(rst_n), .serClk(serClk),
		.serData(serData), .serLatch(serLatch), .pfdTick(pfdTick),
		.withinWide(withinWide), .withinTight(withinTight), .freqWord(freqWord),
		.modWord(modWord), .countersHeld(countersHeld), .pumpThreeState(pumpThreeState),
		.polarityPositive(polarityPositive), .antibacklashShort(antibacklashShort),
		.chargeCancel(chargeCancel), .slipReductionEnable(slipReductionEnable),
		.feedbackDirect(feedbackDirect), .outDivSelect(outDivSelect),
		.rfOutputEnable(rfOutputEnable), .rfOutputPower(rfOutputPower),
		.fastLockWide(fastLockWide), .resyncStrobe(resyncStrobe),
		.lockDetect(lockDetect), .lockPin(lockPin));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one serial word, then settle past the registered outputs
	task automatic wr(input logic [31:0] d);
		host_u.send_word(d);
		repeat (4) @(negedge mclk);
	endtask

	// n detector cycles with the given window results
	task automatic tick(input int n, input logic wd, input logic tt);
		repeat (n) begin
			@(negedge mclk);
			pfdTick = 1'b1;
			withinWide = wd;
			withinTight = tt;
			@(negedge mclk);
			pfdTick = 1'h0;
		end
		repeat (2) @(negedge mclk);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// strobe counter and hang guard
	always @(posedge mclk) begin
		if (resyncStrobe === 1'b1)
			pulses++;
		cycles++;
		if (cycles == 40000) begin
			failures++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk(freqWord, pll_ctrl_pkg::REG_RESET);
		// power-up order 5 down to 0, passive filter polarity
		wr(32'h0040_0005);
		wr(32'h00b0_0034);
		wr(32'h0064_0003);
		wr(32'h0000_0142);
		wr(32'h0abc_0001);
		wr(F0);
		chk(freqWord, F0);
		chk(modWord, 32'h0abc_0001);
		chk(polarityPositive, 1);
		chk({antibacklashShort, chargeCancel, slipReductionEnable}, 7);
		chk({feedbackDirect, outDivSelect, rfOutputPower}, 6'h2e);
		chk({rfOutputEnable, countersHeld, pumpThreeState}, 4);
		// integer-N lock needs five in-window cycles
		tick(4, 1, 1);
		chk(lockDetect, 0);
		tick(1, 1, 1);
		chk({lockDetect, lockPin}, 3);
		tick(1, 0, 0);
		chk(lockDetect, 0);
		tick(5, 1, 1);
		// every lock pin mode while locked
		for (int m = 0; m < 4; m++) begin
			wr((32'(m) << 22) | 32'h5);
			chk(lockPin, (m == 1 || m == 3));
		end
		// mute till lock, divider applied directly
		wr(32'h0050_0424);
		chk({rfOutputEnable, outDivSelect}, 4'hd);
		tick(1, 0, 0);
		chk(rfOutputEnable, 0);
		// fractional-N with tight window, integer-only extras off first
		wr(32'h0000_0003);
		chk({antibacklashShort, chargeCancel, slipReductionEnable}, 3'h0);
		wr(32'h0000_00c2);
		tick(40, 1, 0);
		chk(lockDetect, 0);
		tick(39, 1, 1);
		chk(lockDetect, 0);
		tick(1, 1, 1);
		chk(lockDetect, 1);
		// double buffered divider waits for register 0
		wr(32'h0000_2042);
		wr(32'h0010_0024);
		chk(outDivSelect, 5);
		wr(F0);
		chk(outDivSelect, 1);
		// fast lock for three detector cycles
		wr(32'h0000_801b);
		wr(F0);
		chk(fastLockWide, 1);
		tick(2, 1, 1);
		chk(fastLockWide, 1);
		tick(1, 1, 1);
		chk(fastLockWide, 0);
		// phase resync after two detector cycles
		wr(32'h0001_0013);
		wr(F0);
		pulseBase = pulses;
		tick(1, 1, 1);
		chk(pulses - pulseBase, 32'h0);
		tick(1, 1, 1);
		chk({4'(pulses - pulseBase), fastLockWide}, 5'h2);
		// unused select code changes nothing
		wr(32'h0000_0006);
		chk(freqWord, F0);
		// counter reset and pump three-state bits
		wr(32'h0000_001a);
		chk({countersHeld, pumpThreeState}, 3);
		wr(32'h0000_0002);
		chk({countersHeld, pumpThreeState}, 0);
		// sleep with lock held, writes still land
		wr(32'h0000_0142);
		tick(5, 1, 1);
		wr(32'h0000_0162);
		chk({lockDetect, countersHeld, pumpThreeState, rfOutputEnable}, 6);
		wr(32'h0def_0001);
		chk(modWord, 32'h0def_0001);
		wr(32'h0000_0142);
		chk({countersHeld, rfOutputEnable, polarityPositive}, 3);
		chk(freqWord, F0);
		print_verdict();
	end
endmodule
